/* core/clk_source_switch.sv */
`include "clk_switch_consts.svh"

module clk_source_switch
  import clk_switch_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic primary_clk,
  input wire logic secondary_clk,
  input wire logic internal_clk,
  input wire logic primary_fail,
  input wire logic secondary_fail,
  input wire logic wake_event,
  input wire logic instr_done,
  output logic [1:0] active_source,
  output logic [2:0] active_freq,
  output logic phase_hold,
  output logic primary_power_en,
  output logic watchdog_enable,
  output logic watchdog_clear,
  output logic core_run
);

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------

  // A crystal primary needs the start-up timer.
  function automatic logic is_crystal(input logic [2:0] mode);
    is_crystal = (mode == FOSC_LP) || (mode == FOSC_XT) ||
      (mode == FOSC_HS);
  endfunction : is_crystal

  // The primary itself is the internal oscillator block.
  function automatic logic is_internal(input logic [2:0] mode);
    is_internal = (mode == FOSC_INT_IO2) || (mode == FOSC_INT_IO1);
  endfunction : is_internal

  // Falling edge seen in a three-stage synchroniser.
  function automatic logic fall(input logic [2:0] s);
    fall = !s[1] && s[2];
  endfunction : fall

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------

  logic [2:0] pclk_sync_q; // Primary clock samples.
  logic [2:0] sclk_sync_q; // Secondary clock samples.
  logic [2:0] iclk_sync_q; // Internal clock samples.
  logic [2:0] pfail_sync_q; // Primary fail samples.
  logic [2:0] sfail_sync_q; // Secondary fail samples.
  logic [2:0] wake_sync_q; // Wake samples.

  // Each pin passes three flops; only stages 1 and 2 are looked at.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pclk_sync_q <= 3'h0;
      sclk_sync_q <= 3'h0;
      iclk_sync_q <= 3'h0;
      pfail_sync_q <= 3'h0;
      sfail_sync_q <= 3'h0;
      wake_sync_q <= 3'h0;
    end else begin
      pclk_sync_q <= {pclk_sync_q[1:0], primary_clk};
      sclk_sync_q <= {sclk_sync_q[1:0], secondary_clk};
      iclk_sync_q <= {iclk_sync_q[1:0], internal_clk};
      pfail_sync_q <= {pfail_sync_q[1:0], primary_fail};
      sfail_sync_q <= {sfail_sync_q[1:0], secondary_fail};
      wake_sync_q <= {wake_sync_q[1:0], wake_event};
    end
  end

  // A rise counts once stages 1 and 2 agree; a fail level drops when stage 1 does.
  logic pfail; // Primary failure level.
  logic sfail; // Secondary failure level.
  logic wake_rise; // Wake event, one cycle.
  logic wake_q; // Last agreed wake level.
  assign pfail = pfail_sync_q[1] && pfail_sync_q[2];
  assign sfail = sfail_sync_q[1] && sfail_sync_q[2];
  assign wake_rise = wake_sync_q[1] && wake_sync_q[2] && !wake_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_q <= 1'b0;
    end else if (wake_sync_q[1] == wake_sync_q[2]) begin
      wake_q <= wake_sync_q[2];
    end
  end

  // ---------------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------------

  logic wr_pend_q; // Write data phase pending.
  logic [11:0] wr_addr_q; // Address of the pending write.
  logic [11:0] rd_addr_q; // Address of the pending read.
  logic rd_pend_q; // Read data phase pending.
  logic addr_ok; // Address phase accepted.
  assign addr_ok = hsel && hready && htrans[1];

  // Capture the address phase; zero wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rd_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      rd_pend_q <= addr_ok && !hwrite;
      wr_addr_q <= haddr;
      rd_addr_q <= haddr;
    end
  end

  // The slave is always ready and always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  logic wr_ctrl; // Write to the control register.
  logic wr_cfg; // Write to the configuration register.
  assign wr_ctrl = wr_pend_q && (wr_addr_q == `OSC_CTRL_BYTE_ADDR);
  assign wr_cfg = wr_pend_q && (wr_addr_q == `CFG_ADDR);

  // ---------------------------------------------------------------------
  // Configuration register: mode, two-speed, fail-safe enable
  // ---------------------------------------------------------------------

  logic [4:0] cfg_q; // Configuration bits.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= 5'h00;
    end else if (wr_cfg) begin
      cfg_q <= hwdata[4:0];
    end
  end

  logic [2:0] fosc; // Primary oscillator mode.
  logic two_speed; // Two-speed start-up enable.
  logic failsafe_monitor_enable; // Fail-safe monitor enable.
  assign fosc = cfg_q[2:0];
  assign two_speed = cfg_q[`CFG_TWO_SPEED_BIT];
  assign failsafe_monitor_enable = cfg_q[`CFG_FAILSAFE_BIT];

  // ---------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------

  logic [1:0] clock_source_select_q; // Requested source.
  logic [2:0] internal_freq_select_q; // Internal frequency.
  logic primary_running_flag_q; // Start-up status flag.
  logic internal_freq_stable_q; // Fast oscillator stable.
  logic [1:0] src_q; // Source now driving the core.
  logic fail_switch; // Fail-safe fallback event.
  logic sw_state_run; // Sequencer idle.

  assign fail_switch = failsafe_monitor_enable && sw_state_run &&
    ((src_q == SRC_PRIMARY && pfail) ||
     (src_q == SRC_SECONDARY && sfail));

  // Software writes; fail-safe forces the internal source.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_source_select_q <= SRC_PRIMARY;
      internal_freq_select_q <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        internal_freq_select_q <= hwdata[6:4];
        clock_source_select_q <= hwdata[1:0];
      end
      if (fail_switch) begin
        clock_source_select_q <= SRC_INTERNAL;
        internal_freq_select_q <= 3'h0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Switch sequencer
  // ---------------------------------------------------------------------

  sw_state_e state_q; // Sequencer state.
  logic [1:0] target_q; // Destination source.
  logic [10:0] su_cnt_q; // Start-up timer count.
  logic [3:0] edge_cnt_q; // Falling edges of the new clock.
  logic new_fall; // Falling edge of the destination clock.
  logic [1:0] req_src; // Effective request.

  assign sw_state_run = (state_q == ST_RUN);
  assign req_src = (clock_source_select_q == SRC_RESERVED) ?
    src_q : clock_source_select_q;
  assign new_fall = (target_q == SRC_PRIMARY) ? fall(pclk_sync_q) :
    (target_q == SRC_SECONDARY) ? fall(sclk_sync_q) :
    fall(iclk_sync_q);

  logic start_reset_q; // First cycle after reset release.
  logic [2:0] last_freq_q; // Frequency at last switch.

  // Sequencer: old cycle, start-up timer, held phase, then swap.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_RUN;
      target_q <= SRC_PRIMARY;
      src_q <= SRC_PRIMARY;
      su_cnt_q <= 11'd0;
      edge_cnt_q <= 4'h0;
      start_reset_q <= 1'b1;
      last_freq_q <= 3'h0;
    end else begin
      start_reset_q <= 1'b0;
      unique case (state_q)
        ST_RUN: begin
          su_cnt_q <= 11'd0;
          edge_cnt_q <= 4'h0;
          if (start_reset_q && is_crystal(fosc)) begin
            // Two-speed runs internal meanwhile; otherwise halted.
            src_q <= two_speed ? SRC_INTERNAL : SRC_PRIMARY;
            target_q <= SRC_PRIMARY;
            state_q <= ST_STARTUP;
          end else if (wake_rise && two_speed && is_crystal(fosc) &&
                       clock_source_select_q == SRC_PRIMARY) begin
            src_q <= SRC_INTERNAL;
            target_q <= SRC_PRIMARY;
            state_q <= ST_STARTUP;
          end else if ((req_src != src_q ||
                        internal_freq_select_q != last_freq_q) &&
                       !(req_src == SRC_INTERNAL &&
                         is_internal(fosc) && src_q == SRC_PRIMARY)) begin
            target_q <= req_src;
            last_freq_q <= internal_freq_select_q;
            state_q <= ST_OLD_CYCLE;
          end else begin
            last_freq_q <= internal_freq_select_q;
          end
        end
        ST_OLD_CYCLE: begin
          // Let the next instruction finish on the old clock.
          if (instr_done) begin
            state_q <= (target_q == SRC_PRIMARY && is_crystal(fosc)) ?
              ST_STARTUP : ST_HOLD;
          end
        end
        ST_STARTUP: begin
          if (fall(pclk_sync_q)) begin
            su_cnt_q <= su_cnt_q + 11'd1;
          end
          if (su_cnt_q == `STARTUP_CYCLES) begin
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (new_fall) begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
          end
          if (edge_cnt_q == `RELEASE_EDGES) begin
            src_q <= target_q;
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------

  logic [$clog2(`SETTLE_CYCLES + 1)-1:0] settle_q; // Settle counter.

  // Start-up flag follows the source actually in use.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_running_flag_q <= 1'b0;
    end else if (state_q == ST_HOLD && edge_cnt_q == `RELEASE_EDGES) begin
      primary_running_flag_q <= (target_q == SRC_PRIMARY);
    end else if (start_reset_q && !is_crystal(fosc)) begin
      // A crystal primary only sets the flag once its timer has run out.
      primary_running_flag_q <= 1'b1;
    end
  end

  // Fast oscillator settles after a switch from a non-internal clock.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_q <= '0;
      internal_freq_stable_q <= 1'b0;
    end else if (src_q != SRC_INTERNAL &&
                 (state_q != ST_RUN || !sw_state_run)) begin
      settle_q <= '0;
      internal_freq_stable_q <= 1'b0;
    end else if (internal_freq_select_q == 3'h0) begin
      internal_freq_stable_q <= 1'b0;
    end else if (settle_q >= SETTLE_CYCLES - 1) begin
      internal_freq_stable_q <= 1'b1;
    end else begin
      settle_q <= settle_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------

  // Registered outputs driving the clock tree and watchdog.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_source <= SRC_PRIMARY;
      active_freq <= 3'h0;
      phase_hold <= 1'b0;
      primary_power_en <= 1'b1;
      watchdog_enable <= 1'b1;
      watchdog_clear <= 1'b0;
      core_run <= 1'b0;
    end else begin
      active_source <= src_q;
      active_freq <= internal_freq_select_q;
      phase_hold <= (state_q == ST_HOLD);
      primary_power_en <= (src_q == SRC_PRIMARY) ||
        (target_q == SRC_PRIMARY);
      watchdog_enable <= sw_state_run;
      watchdog_clear <= (state_q == ST_HOLD) &&
        (edge_cnt_q == `RELEASE_EDGES);
      core_run <= !(state_q == ST_HOLD) &&
        !(state_q == ST_STARTUP && !two_speed) && !start_reset_q;
    end
  end

  // Read data, reserved top bit zero, unmapped reads zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      if (haddr == `OSC_CTRL_BYTE_ADDR) begin
        hrdata <= {24'h000000, 1'b0, internal_freq_select_q,
          primary_running_flag_q, internal_freq_stable_q,
          clock_source_select_q};
      end else if (haddr == `CFG_ADDR) begin
        hrdata <= {27'h0000000, cfg_q};
      end else if (haddr == `STAT_ADDR) begin
        hrdata <= {24'h000000, state_q, 2'h0, src_q};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

endmodule : clk_source_switch

/* core/clk_switch_consts.svh */
`ifndef CLK_SWITCH_CONSTS_SVH
`define CLK_SWITCH_CONSTS_SVH
// Register map, field positions and reset values.
`define OSC_CTRL_ADDR 12'h08F
`define OSC_CTRL_IDX 8'h8F
`define OSC_CTRL_BYTE_ADDR 12'h23C
`define CFG_ADDR 12'h240
`define STAT_ADDR 12'h244
`define SRC_SEL_LSB 0
`define FREQ_STABLE_BIT 2
`define PRIM_RUN_BIT 3
`define FREQ_SEL_LSB 4
`define OSC_CTRL_RESET 8'h00
`define CFG_RESET 8'h00
`define CFG_FOSC_LSB 0
`define CFG_TWO_SPEED_BIT 3
`define CFG_FAILSAFE_BIT 4
// Timing: start-up count, release edge count, settle time of fast osc.
`define STARTUP_CYCLES 11'd1024
`define RELEASE_EDGES 4'd8
`define SETTLE_US 4000
`define CLK_MHZ 20
`define SETTLE_CYCLES (`SETTLE_US * `CLK_MHZ)
`endif

/* core/clk_switch_pkg.sv */
package clk_switch_pkg;
  // System clock sources as coded in the source-select field.
  typedef enum logic [1:0] {
    SRC_PRIMARY = 2'h0,
    SRC_SECONDARY = 2'h1,
    SRC_INTERNAL = 2'h2,
    SRC_RESERVED = 2'h3
  } src_e;
  // Switch sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_OLD_CYCLE = 4'h2,
    ST_STARTUP = 4'h4,
    ST_HOLD = 4'h8
  } sw_state_e;
  // Primary oscillator modes of the configuration field.
  typedef enum logic [2:0] {
    FOSC_LP = 3'h0,
    FOSC_XT = 3'h1,
    FOSC_HS = 3'h2,
    FOSC_EC = 3'h3,
    FOSC_INT_IO2 = 3'h4,
    FOSC_INT_IO1 = 3'h5,
    FOSC_RC = 3'h6,
    FOSC_RC_CLK = 3'h7
  } fosc_e;
endpackage : clk_switch_pkg

/* testbench/clk_source_switch_props.sv */
`include "clk_switch_consts.svh"

module clk_source_switch_props
  import clk_switch_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] active_source,
  input wire logic [2:0] active_freq,
  input wire logic phase_hold,
  input wire logic watchdog_enable,
  input wire logic watchdog_clear
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic take_ctrl; // A transfer to the control register is taken.
  logic wr_ph_q; // The control register write is in its data phase.
  logic [2:0] freq_q; // Frequency code carried by the last write.

  assign take_ctrl = hsel && hready && htrans[1] &&
                     haddr == `OSC_CTRL_BYTE_ADDR;

  // Marks the data phase of a control register write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
    end else begin
      wr_ph_q <= take_ctrl && hwrite;
    end
  end

  // Captures the written frequency code so it can be compared later.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_q <= 3'h0;
    end else if (wr_ph_q) begin
      freq_q <= hwdata[6:4];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_top_bit_zero: assert property (
    take_ctrl && !hwrite |=> hrdata[7] == 1'b0)
    else $error("Control read shows the top bit set.");
  chk_freq_follow: assert property (
    wr_ph_q |=> ##[0:1] active_freq == freq_q)
    else $error("Frequency output did not follow the write.");
  chk_src_legal: assert property (
    active_source != SRC_RESERVED)
    else $error("Reserved source code is in use.");
  chk_wd_off_hold: assert property (
    phase_hold |-> !watchdog_enable)
    else $error("Watchdog runs while a switch holds the phases.");
  chk_clear_pulse: assert property (
    watchdog_clear |=> !watchdog_clear)
    else $error("Watchdog clear is longer than one cycle.");
  chk_wd_return_clear: assert property (
    $rose(watchdog_enable) |-> watchdog_clear || $past(watchdog_clear))
    else $error("Watchdog came back without a clear.");
  chk_hold_length: assert property (
    $rose(phase_hold) |-> phase_hold [*8])
    else $error("Phase hold released too early.");
  chk_mux_held: assert property (
    $changed(active_source) |-> phase_hold || $past(phase_hold))
    else $error("Source changed without the phases held.");
endmodule : clk_source_switch_props

/* testbench/clk_source_switch_test.sv */
`include "clk_switch_consts.svh"

module clk_source_switch_test
  import clk_switch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans, active_source;
  logic [2:0] hsize, active_freq;
  logic [31:0] hwdata, hrdata;
  logic primary_clk, secondary_clk, internal_clk, primary_fail;
  logic secondary_fail, wake_event, instr_done, phase_hold;
  logic primary_power_en, watchdog_enable, watchdog_clear, core_run;
  logic [3:0] osc_cnt; // Divider that makes the slow oscillators.
  int failures, tests_run, cycles, clr_cnt;

  assign hready = hreadyout;

  clk_source_switch #(.SETTLE_CYCLES(20)) i_clk_source_switch (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .primary_clk, .secondary_clk,
    .internal_clk, .primary_fail, .secondary_fail, .wake_event,
    .instr_done, .active_source, .active_freq, .phase_hold,
    .primary_power_en, .watchdog_enable, .watchdog_clear, .core_run);

  // 50 ns clock.
  always #25 hclk = ~hclk;

  // Oscillators; the primary one stops while it is powered down.
  always @(posedge hclk) begin
    osc_cnt <= osc_cnt + 4'h1;
    primary_clk <= osc_cnt[1] & primary_power_en;
    internal_clk <= osc_cnt[2];
    secondary_clk <= osc_cnt[3];
    clr_cnt <= clr_cnt + int'(watchdog_clear === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic wrap_up;
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Compares one value and counts it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // One single word transfer; the address phase waits for ready.
  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Holds reset for 16 cycles.
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : do_reset

  // Waits, bounded, for a source to become active and checks it.
  task automatic wait_src(input logic [1:0] s);
    for (int n = 0; n < 9000 && active_source !== s; n++) @(posedge hclk);
    check({30'h0, active_source}, {30'h0, s});
  endtask : wait_src

  // Waits, bounded, until the watchdog runs again and execution may go.
  task automatic wait_idle;
    for (int n = 0; n < 9000 && (watchdog_enable & core_run) !== 1'b1;
         n++) @(posedge hclk);
    check({31'h0, watchdog_enable & core_run}, 32'h1);
  endtask : wait_idle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, an unmapped read and the start-up wait.
  task automatic t_after_reset;
    logic [31:0] rd;
    int n;
    check({31'h0, core_run}, 32'h0);
    bus(`OSC_CTRL_BYTE_ADDR, 1'b0, 32'h0, rd);
    check(rd & 32'hFFFF_FFFB, 32'h0);
    check({31'h0, hresp}, 32'h0);
    bus(12'h300, 1'b0, 32'h0, rd);
    check(rd, 32'h0);
    for (n = 0; n < 9000 && core_run !== 1'b1; n++) @(posedge hclk);
    check({31'h0, n >= 4000 && core_run === 1'b1}, 32'h1);
    bus(`OSC_CTRL_BYTE_ADDR, 1'b0, 32'h0, rd);
    check({31'h0, rd[3]}, 32'h1);
  endtask : t_after_reset

  // Move to the internal source while the old instruction lingers.
  task automatic t_to_internal;
    logic [31:0] rd;
    int c;
    c = clr_cnt;
    instr_done <= 1'b0;
    bus(`OSC_CTRL_BYTE_ADDR, 1'b1, 32'h72, rd);
    repeat (10) @(posedge hclk);
    check({30'h0, active_source}, 32'h0);
    instr_done <= 1'b1;
    wait_src(SRC_INTERNAL);
    check({31'h0, primary_power_en}, 32'h0);
    wait_idle();
    check({31'h0, clr_cnt > c}, 32'h1);
    repeat (200) @(posedge hclk);
    bus(`OSC_CTRL_BYTE_ADDR, 1'b0, 32'h0, rd);
    check(rd & 32'hC, 32'h4);
  endtask : t_to_internal

  // Every frequency code reaches the output and reads back.
  task automatic t_freq_codes;
    logic [31:0] rd;
    for (int k = 0; k < 8; k++) begin
      bus(`OSC_CTRL_BYTE_ADDR, 1'b1, {25'h0, k[2:0], 4'h2}, rd);
      repeat (2) @(posedge hclk);
      check({29'h0, active_freq}, k);
      wait_idle();
      bus(`OSC_CTRL_BYTE_ADDR, 1'b0, 32'h0, rd);
      check({29'h0, rd[6:4]}, k);
    end
  endtask : t_freq_codes

  // Secondary source, fail-safe fallbacks and the return to primary.
  task automatic t_switching;
    logic [31:0] rd;
    bus(`OSC_CTRL_BYTE_ADDR, 1'b1, 32'h71, rd);
    wait_src(SRC_SECONDARY);
    wait_idle();
    bus(`OSC_CTRL_BYTE_ADDR, 1'b0, 32'h0, rd);
    check({31'h0, rd[3]}, 32'h0);
    bus(`CFG_ADDR, 1'b1, 32'h10, rd);
    secondary_fail <= 1'b1;
    wait_src(SRC_INTERNAL);
    secondary_fail <= 1'b0;
    wait_idle();
    bus(`OSC_CTRL_BYTE_ADDR, 1'b1, 32'h70, rd);
    wait_src(SRC_PRIMARY);
    wait_idle();
    bus(`OSC_CTRL_BYTE_ADDR, 1'b0, 32'h0, rd);
    check({31'h0, rd[3]}, 32'h1);
    primary_fail <= 1'b1;
    wait_src(SRC_INTERNAL);
    primary_fail <= 1'b0;
  endtask : t_switching

  // Reset in mid-run, then an internal select with internal primary.
  task automatic t_reset_no_switch;
    logic [31:0] rd;
    logic ok;
    do_reset();
    @(posedge hclk);
    check({30'h0, active_source}, 32'h0);
    bus(`OSC_CTRL_BYTE_ADDR, 1'b0, 32'h0, rd);
    check({30'h0, rd[1:0]}, 32'h0);
    wait_idle();
    bus(`CFG_ADDR, 1'b1, 32'h04, rd);
    bus(`OSC_CTRL_BYTE_ADDR, 1'b1, 32'h72, rd);
    ok = 1'b1;
    repeat (60) begin
      @(posedge hclk);
      ok = ok & (watchdog_enable === 1'b1);
    end
    check({31'h0, ok}, 32'h1);
  endtask : t_reset_no_switch

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {hclk, hsel, hwrite, haddr, htrans, hwdata, osc_cnt} = '0;
    {primary_clk, secondary_clk, internal_clk} = 3'h0;
    {primary_fail, secondary_fail, wake_event} = 3'h0;
    {failures, tests_run, cycles, clr_cnt} = '0;
    hresetn = 1'b0;
    hsize = 3'h2;
    instr_done = 1'b1;
    do_reset();
    t_after_reset();
    t_to_internal();
    t_freq_codes();
    t_switching();
    t_reset_no_switch();
    wrap_up();
  end
endmodule : clk_source_switch_test

bind clk_source_switch clk_source_switch_props i_clk_source_switch_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .active_source, .active_freq, .phase_hold, .watchdog_enable,
  .watchdog_clear);
